// ==== verilog/aacbe_exec.sv ====
// Top of the execute block: phase sequencer, decode, datapath and register port.
// Assumes fetch presents the word at Q1 and data memory answers one cycle after rd.
`timescale 1ns/1ps
`include "aacbe_cfg.svh"

module aacbe_exec
#(
    parameter int ADDR_W = `AACBE_DM_ADDR_W,
    parameter int PC_W   = `AACBE_PC_W
)
(
    input  wire logic                    i_clk,
    input  wire logic                    i_rstn,
    input  wire logic                    i_ce,
    input  wire logic [15:0]             i_instr,
    input  wire logic                    i_carry,
    input  wire logic [7:0]              i_dm_rdata,
    input  wire logic [ADDR_W-1:0]       i_index_base,
    input  wire logic [3:0]              i_reg_addr,
    input  wire logic [7:0]              i_reg_wdata,
    input  wire logic                    i_reg_wr,
    input  wire logic                    i_reg_rd,
    output aacbe_pkg::aacbe_dm_req_t     o_dm,
    output logic      [PC_W-1:0]         o_pc,
    output logic                         o_flush,
    output logic      [7:0]              o_result,
    output logic                         o_result_valid,
    output logic      [7:0]              o_wreg,
    output logic      [7:0]              o_reg_rdata
);

    initial
    begin
        if (ADDR_W != `AACBE_DM_ADDR_W)
            $error("aacbe_exec address width must match the request struct.");
        if (PC_W < 10)
            $error("aacbe_exec needs a program counter of ten bits or more.");
    end

    logic                   rst_s1_q;
    logic                   rst_n;
    aacbe_pkg::aacbe_phase_t phase_q;
    aacbe_pkg::aacbe_dec_t  dec_q;
    aacbe_pkg::aacbe_dec_t  dec_d;
    logic                   taken_q;
    logic [7:0]             ctrl_q;
    logic [7:0]             bank_q;
    logic [ADDR_W-1:0]      addr_d;
    logic [7:0]             result_d;
    logic [PC_W-1:0]        disp_d;
    logic                   ext_en;

    assign ext_en = ctrl_q[`AACBE_CTRL_EXT_BIT];

    // Reset is asserted at once but released through two flops.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Phase sequencer, one instruction cycle every four clocks.
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            phase_q <= aacbe_pkg::PH_Q1;
        else if (i_ce)
        begin
            case (phase_q)
                aacbe_pkg::PH_Q1: phase_q <= aacbe_pkg::PH_Q2;
                aacbe_pkg::PH_Q2: phase_q <= aacbe_pkg::PH_Q3;
                aacbe_pkg::PH_Q3: phase_q <= aacbe_pkg::PH_Q4;
                default:          phase_q <= aacbe_pkg::PH_Q1;
            endcase
        end
    end

    // Decode. The word fetched behind a taken branch decodes as a no-operation.
    always_comb
    begin
        dec_d           = '0;
        dec_d.kind      = aacbe_pkg::K_NOP;
        dec_d.dest_file = i_instr[9];
        dec_d.bank_sel  = i_instr[8];
        dec_d.lit       = i_instr[7:0];
        if (o_flush)
            dec_d.kind = aacbe_pkg::K_NOP;
        else if (i_instr[15:10] == `AACBE_OP_AND_WREG_WITH_FILE)
            dec_d.kind = aacbe_pkg::K_AND_WREG_WITH_FILE;
        else if (i_instr[15:8] == `AACBE_OP_AND_LITERAL_INTO_WREG)
            dec_d.kind = aacbe_pkg::K_AND_LITERAL_INTO_WREG;
        else if (i_instr[15:8] == `AACBE_OP_BRANCH_ON_CARRY)
            dec_d.kind = aacbe_pkg::K_BRANCH_ON_CARRY;
    end

    aacbe_addr
    #(
        .ADDR_W       (ADDR_W)
    )
    u_addr
    (
        .i_bank_sel   (dec_d.bank_sel),
        .i_ext_en     (ext_en),
        .i_file       (dec_d.lit),
        .i_bank       (bank_q[ADDR_W-9:0]),
        .i_index_base (i_index_base),
        .o_addr       (addr_d)
    );

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            dec_q <= '0;
        else if (i_ce && (phase_q == aacbe_pkg::PH_Q1))
            dec_q <= dec_d;
    end

    // Data memory requests: read during Q2, write during Q4.
    assign result_d = o_wreg &
        ((dec_q.kind == aacbe_pkg::K_AND_WREG_WITH_FILE) ? i_dm_rdata : dec_q.lit);

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_dm <= '0;
        else if (i_ce)
        begin
            o_dm.rd <= 1'b0;
            o_dm.wr <= 1'b0;
            case (phase_q)
                aacbe_pkg::PH_Q1:
                begin
                    if (dec_d.kind == aacbe_pkg::K_AND_WREG_WITH_FILE)
                    begin
                        o_dm.addr <= addr_d;
                        o_dm.rd   <= 1'b1;
                    end
                end
                aacbe_pkg::PH_Q3:
                begin
                    if ((dec_q.kind == aacbe_pkg::K_AND_WREG_WITH_FILE) && dec_q.dest_file)
                    begin
                        o_dm.wr    <= 1'b1;
                        o_dm.wdata <= result_d;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // Process step: the AND result is ready during Q4 for the status logic.
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_result       <= 8'h00;
            o_result_valid <= 1'b0;
        end
        else if (i_ce)
        begin
            o_result_valid <= 1'b0;
            if ((phase_q == aacbe_pkg::PH_Q3) &&
                ((dec_q.kind == aacbe_pkg::K_AND_WREG_WITH_FILE) ||
                 (dec_q.kind == aacbe_pkg::K_AND_LITERAL_INTO_WREG)))
            begin
                o_result       <= result_d;
                o_result_valid <= 1'b1;
            end
        end
    end

    // Working register. An instruction write in Q4 beats a port write in the same cycle.
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_wreg <= `AACBE_WREG_RST;
        else if (i_ce)
        begin
            if (o_result_valid &&
                ((dec_q.kind == aacbe_pkg::K_AND_LITERAL_INTO_WREG) || !dec_q.dest_file))
                o_wreg <= o_result;
            else if (i_reg_wr && (i_reg_addr == `AACBE_REG_WREG))
                o_wreg <= i_reg_wdata;
        end
    end

    // Branch: carry is sampled in Q3, the counter is written in Q4.
    assign disp_d = {{(PC_W-9){dec_q.lit[7]}}, dec_q.lit, 1'b0};

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            taken_q <= 1'b0;
        else if (i_ce && (phase_q == aacbe_pkg::PH_Q3))
            taken_q <= (dec_q.kind == aacbe_pkg::K_BRANCH_ON_CARRY) && i_carry;
    end

    // The counter steps past the fetched word in Q1, except in the flush cycle,
    // so the branch adds its offset to an already incremented counter.
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_pc <= `AACBE_PC_RST;
        else if (i_ce)
        begin
            if ((phase_q == aacbe_pkg::PH_Q1) && !o_flush)
                o_pc <= o_pc + PC_W'(`AACBE_PC_STEP);
            else if ((phase_q == aacbe_pkg::PH_Q4) && taken_q)
                o_pc <= o_pc + disp_d;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_flush <= 1'b0;
        else if (i_ce && (phase_q == aacbe_pkg::PH_Q4))
            o_flush <= taken_q;
    end

    // Register port.
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= `AACBE_CTRL_RST;
            bank_q <= `AACBE_BANK_RST;
        end
        else if (i_ce && i_reg_wr)
        begin
            if (i_reg_addr == `AACBE_REG_CTRL)
                ctrl_q <= {7'h00, i_reg_wdata[`AACBE_CTRL_EXT_BIT]};
            if (i_reg_addr == `AACBE_REG_BANK)
                bank_q <= {{(16-ADDR_W){1'b0}}, i_reg_wdata[ADDR_W-9:0]};
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_reg_rdata <= 8'h00;
        else if (i_ce)
        begin
            o_reg_rdata <= 8'h00;
            if (i_reg_rd)
            begin
                case (i_reg_addr)
                    `AACBE_REG_CTRL: o_reg_rdata <= ctrl_q;
                    `AACBE_REG_BANK: o_reg_rdata <= bank_q;
                    `AACBE_REG_WREG: o_reg_rdata <= o_wreg;
                    `AACBE_REG_STAT: o_reg_rdata <= {4'h0, taken_q, o_flush, phase_q};
                    default:         o_reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Checks.
    phase_order_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && phase_q == aacbe_pkg::PH_Q1) |=> (phase_q == aacbe_pkg::PH_Q2))
        else $error("Phase did not advance from decode to read.");

    file_read_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && phase_q == aacbe_pkg::PH_Q1 && !o_flush &&
         i_instr[15:10] == `AACBE_OP_AND_WREG_WITH_FILE) |=> o_dm.rd)
        else $error("Register AND did not read its operand.");

    and_result_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && phase_q == aacbe_pkg::PH_Q3 && dec_q.kind == aacbe_pkg::K_AND_WREG_WITH_FILE)
        |=> (o_result_valid && o_result == ($past(o_wreg) & $past(i_dm_rdata))))
        else $error("Register AND result is wrong.");

    file_dest_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && phase_q == aacbe_pkg::PH_Q3 && dec_q.kind == aacbe_pkg::K_AND_WREG_WITH_FILE &&
         dec_q.dest_file) |=> (o_dm.wr && o_dm.wdata == o_result))
        else $error("Result was not written back to the file register.");

    w_dest_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && o_result_valid && dec_q.kind == aacbe_pkg::K_AND_WREG_WITH_FILE &&
         !dec_q.dest_file)
        |=> (o_wreg == $past(o_result) && !o_dm.wr))
        else $error("Result did not land in the working register.");

    bank_addr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && phase_q == aacbe_pkg::PH_Q1 && dec_d.kind == aacbe_pkg::K_AND_WREG_WITH_FILE &&
         i_instr[8]) |=> (o_dm.addr == {$past(bank_q[ADDR_W-9:0]), $past(i_instr[7:0])}))
        else $error("Banked address is wrong.");

    indexed_addr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && phase_q == aacbe_pkg::PH_Q1 && dec_d.kind == aacbe_pkg::K_AND_WREG_WITH_FILE &&
         !i_instr[8] && ext_en && i_instr[7:0] <= `AACBE_IDX_MAX)
        |=> (o_dm.addr == $past(i_index_base) + ADDR_W'($past(i_instr[7:0]))))
        else $error("Indexed literal offset address is wrong.");

    branch_taken_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && phase_q == aacbe_pkg::PH_Q4 && taken_q)
        |=> (o_pc == $past(o_pc) + $past(disp_d) && o_flush))
        else $error("Taken branch target or flush is wrong.");

    branch_idle_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && phase_q == aacbe_pkg::PH_Q4 && !taken_q) |=> (o_pc == $past(o_pc) && !o_flush))
        else $error("Branch moved the counter without carry.");

    flush_quiet_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (o_flush && phase_q == aacbe_pkg::PH_Q2) |-> (!o_dm.rd && !o_dm.wr && !o_result_valid))
        else $error("Flush cycle performed an operation.");

endmodule

// ==== verilog/aacbe_cfg.svh ====
// Constants for the AND and carry-branch execute block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef AACBE_CFG_SVH
`define AACBE_CFG_SVH

// Data memory address width and program counter width.
`define AACBE_DM_ADDR_W     12
`define AACBE_PC_W          21

// Opcode patterns, compared against the top bits of the instruction word.
`define AACBE_OP_AND_WREG_WITH_FILE     6'h05
`define AACBE_OP_AND_LITERAL_INTO_WREG  8'h0B
`define AACBE_OP_BRANCH_ON_CARRY        8'hE2

// Access bank split and indexed literal offset limit.
`define AACBE_ACC_SPLIT     8'h60
`define AACBE_IDX_MAX       8'h5F

// Program counter step for one instruction word.
`define AACBE_PC_STEP       2

// Register port offsets.
`define AACBE_REG_CTRL      4'h0
`define AACBE_REG_BANK      4'h1
`define AACBE_REG_WREG      4'h2
`define AACBE_REG_STAT      4'h3

// Control register field position and reset values of the registers and counter.
`define AACBE_CTRL_EXT_BIT  0
`define AACBE_CTRL_RST      8'h00
`define AACBE_BANK_RST      8'h00
`define AACBE_WREG_RST      8'h00
`define AACBE_PC_RST        21'h000000

`endif

// ==== verilog/aacbe_pkg.sv ====
// Types for the AND and carry-branch execute block.
// Assumes aacbe_cfg.svh is on the include path.
`include "aacbe_cfg.svh"

package aacbe_pkg;

    // Gray-coded instruction cycle phases.
    typedef enum logic [1:0] {
        PH_Q1 = 2'h0,
        PH_Q2 = 2'h1,
        PH_Q3 = 2'h3,
        PH_Q4 = 2'h2
    } aacbe_phase_t;

    typedef enum logic [1:0] {
        K_NOP                   = 2'h0,
        K_AND_LITERAL_INTO_WREG = 2'h1,
        K_AND_WREG_WITH_FILE    = 2'h2,
        K_BRANCH_ON_CARRY       = 2'h3
    } aacbe_kind_t;

    typedef struct packed {
        aacbe_kind_t kind;
        logic        dest_file;
        logic        bank_sel;
        logic [7:0]  lit;
    } aacbe_dec_t;

    typedef struct packed {
        logic [`AACBE_DM_ADDR_W-1:0] addr;
        logic                        rd;
        logic                        wr;
        logic [7:0]                  wdata;
    } aacbe_dm_req_t;

endpackage

// ==== verilog/aacbe_addr.sv ====
// Data memory address former for file instructions.
// Assumes all inputs are steady while the caller samples the result.
`timescale 1ns/1ps
`include "aacbe_cfg.svh"

module aacbe_addr
#(
    parameter int ADDR_W = `AACBE_DM_ADDR_W
)
(
    input  wire logic              i_bank_sel,
    input  wire logic              i_ext_en,
    input  wire logic [7:0]        i_file,
    input  wire logic [ADDR_W-9:0] i_bank,
    input  wire logic [ADDR_W-1:0] i_index_base,
    output logic      [ADDR_W-1:0] o_addr
);

    initial
    begin
        if (ADDR_W < 9)
            $error("aacbe_addr needs at least nine address bits.");
    end

    always_comb
    begin
        if (i_bank_sel)
            o_addr = {i_bank, i_file};
        else if (i_ext_en && (i_file <= `AACBE_IDX_MAX))
            o_addr = i_index_base + {{(ADDR_W-8){1'b0}}, i_file};
        else if (i_file < `AACBE_ACC_SPLIT)
            o_addr = {{(ADDR_W-8){1'b0}}, i_file};
        else
            o_addr = {{(ADDR_W-8){1'b1}}, i_file};
    end

endmodule

// ==== dv/aacbe_mem.sv ====
// Behavioural program memory and data memory facing the execute block.
// Assumes the bench loads both arrays while reset is held.
`timescale 1ns/1ps
`include "aacbe_cfg.svh"

module aacbe_mem
(
    input  wire logic                     i_clk,
    input  wire logic                     i_ce,
    input  wire logic [`AACBE_PC_W-1:0]   i_pc,
    input  wire aacbe_pkg::aacbe_dm_req_t i_dm,
    output logic      [15:0]              o_instr,
    output logic      [7:0]               o_rdata
);
    logic [15:0] prog [0:1023];
    logic [7:0]  dmem [0:4095];
    logic [7:0]  data_q;
    logic        valid_q;

    assign o_instr = prog[i_pc[10:1]];
    // Outside the hold window the byte is inverted, so a late sample is seen as wrong.
    assign o_rdata = valid_q ? data_q : ~data_q;

    // The byte is kept while the clock enable is low, since that stretches the window.
    always @(posedge i_clk)
    begin
        if (i_dm.rd)
        begin
            data_q  <= dmem[i_dm.addr];
            valid_q <= 1'b1;
        end
        else if (i_ce)
        begin
            valid_q <= 1'b0;
        end
        if (i_dm.wr)
        begin
            dmem[i_dm.addr] <= i_dm.wdata;
        end
    end
endmodule

// ==== dv/and_and_carry_branch_exec_bench.sv ====
// Self-checking bench for the AND and carry-branch execute block.
// Assumes aacbe_mem stands in for program and data memory.
`timescale 1ns/1ps
`include "aacbe_cfg.svh"

`define AACBE_CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module and_and_carry_branch_exec_bench;
    logic                        i_clk        = 1'b0;
    logic                        i_rstn       = 1'b0;
    logic                        i_ce         = 1'b1;
    logic                        i_carry      = 1'b0;
    logic [`AACBE_DM_ADDR_W-1:0] i_index_base = 12'h000;
    logic [3:0]                  i_reg_addr   = 4'h0;
    logic [7:0]                  i_reg_wdata  = 8'h00;
    logic                        i_reg_wr     = 1'b0;
    logic                        i_reg_rd     = 1'b0;
    logic [15:0]                 instr;
    logic [7:0]                  rdata;
    aacbe_pkg::aacbe_dm_req_t    dm;
    logic [`AACBE_PC_W-1:0]      pc;
    logic                        flush;
    logic [7:0]                  result;
    logic                        rvalid;
    logic [7:0]                  wreg;
    logic [7:0]                  reg_rdata;
    int                          fail_count   = 0;
    int                          total_checks = 0;
    int                          edges;
    int                          rel;
    int                          nres;

    always #20 i_clk = ~i_clk;

    // Counts enabled edges from the internal reset release, so stalls stay transparent.
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rel   <= 0;
            edges <= 0;
        end
        else if (rel < 2)
            rel <= rel + 1;
        else if (i_ce)
            edges <= edges + 1;
    end

    // Counts result pulses so that each AND reports exactly once.
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            nres <= 0;
        else if (i_ce && rvalid)
            nres <= nres + 1;
    end

    aacbe_exec u_dut
    (
        .i_clk          (i_clk),
        .i_rstn         (i_rstn),
        .i_ce           (i_ce),
        .i_instr        (instr),
        .i_carry        (i_carry),
        .i_dm_rdata     (rdata),
        .i_index_base   (i_index_base),
        .i_reg_addr     (i_reg_addr),
        .i_reg_wdata    (i_reg_wdata),
        .i_reg_wr       (i_reg_wr),
        .i_reg_rd       (i_reg_rd),
        .o_dm           (dm),
        .o_pc           (pc),
        .o_flush        (flush),
        .o_result       (result),
        .o_result_valid (rvalid),
        .o_wreg         (wreg),
        .o_reg_rdata    (reg_rdata)
    );

    aacbe_mem u_mem
    (
        .i_clk   (i_clk),
        .i_ce    (i_ce),
        .i_pc    (pc),
        .i_dm    (dm),
        .o_instr (instr),
        .o_rdata (rdata)
    );

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1;
        `AACBE_CHK(nm, e, reg_rdata)
    endtask

    // Waits for the end of n instruction cycles; checks land where outputs are settled.
    task automatic upto(input int n);
        while (edges != 4 * n) @(negedge i_clk);
    endtask

    task automatic rst_hold();
        i_rstn <= 1'b0;
        @(posedge i_clk);
        for (int i = 0; i < 1024; i++) u_mem.prog[i] = 16'h0000;
    endtask

    task automatic rst_release();
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_clk);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        rst_hold();
        u_mem.prog[8]       = 16'h0B5F;
        u_mem.prog[9]       = 16'h1420;
        u_mem.prog[10]      = 16'h1734;
        u_mem.prog[11]      = 16'h1680;
        u_mem.dmem[12'h020] = 8'hC2;
        u_mem.dmem[12'h534] = 8'hFF;
        u_mem.dmem[12'hF80] = 8'h0E;
        rst_release();
        // The read is taken at the end of the read phase of the first cycle.
        rd_chk("stat", `AACBE_REG_STAT, 8'h01);
        rd_chk("ctrl reset", `AACBE_REG_CTRL, `AACBE_CTRL_RST);
        rd_chk("wreg reset", `AACBE_REG_WREG, `AACBE_WREG_RST);
        reg_wr(`AACBE_REG_BANK, 8'h05);
        reg_wr(`AACBE_REG_WREG, 8'hA3);
        reg_wr(4'h9, 8'h55);
        rd_chk("bank", `AACBE_REG_BANK, 8'h05);
        rd_chk("unmapped", 4'h9, 8'h00);
        upto(9);
        `AACBE_CHK("wreg literal", 8'h03, wreg)
        `AACBE_CHK("result literal", 8'h03, result)
        upto(10);
        // A stall in Q3, after the read and before the AND, must not lose the operand.
        repeat (2) @(posedge i_clk);
        i_ce <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_ce <= 1'b1;
        upto(13);
        `AACBE_CHK("wreg and", 8'h02, wreg)
        `AACBE_CHK("file kept", 8'hC2, u_mem.dmem[12'h020])
        `AACBE_CHK("banked wr", 8'h02, u_mem.dmem[12'h534])
        `AACBE_CHK("access wr", 8'h02, u_mem.dmem[12'hF80])
        `AACBE_CHK("pc", 21'h00001A, pc)
        `AACBE_CHK("result pulses", 4, nres)
        $display("test and_ops done");

        rst_hold();
        i_index_base        <= 12'h300;
        u_mem.prog[8]       = 16'h165F;
        u_mem.prog[9]       = 16'h1660;
        u_mem.prog[10]      = 16'hE205;
        u_mem.prog[16]      = 16'hE280;
        u_mem.prog[17]      = 16'hE280;
        u_mem.dmem[12'h35F] = 8'h3C;
        u_mem.dmem[12'h05F] = 8'h3C;
        u_mem.dmem[12'hF60] = 8'hA5;
        rst_release();
        reg_wr(`AACBE_REG_CTRL, 8'h01);
        reg_wr(`AACBE_REG_WREG, 8'h0F);
        upto(10);
        @(posedge i_clk);
        i_carry <= 1'b1;
        upto(11);
        `AACBE_CHK("flush on", 1'b1, flush)
        `AACBE_CHK("target fwd", 21'h000020, pc)
        @(posedge i_clk);
        i_carry <= 1'b0;
        upto(12);
        `AACBE_CHK("flush off", 1'b0, flush)
        `AACBE_CHK("pc held", 21'h000020, pc)
        upto(13);
        `AACBE_CHK("no branch", 21'h000022, pc)
        `AACBE_CHK("no flush", 1'b0, flush)
        @(posedge i_clk);
        i_carry <= 1'b1;
        upto(15);
        `AACBE_CHK("target back", 21'h1FFF24, pc)
        `AACBE_CHK("wreg kept", 8'h0F, wreg)
        `AACBE_CHK("indexed", 8'h0C, u_mem.dmem[12'h35F])
        `AACBE_CHK("direct kept", 8'h3C, u_mem.dmem[12'h05F])
        `AACBE_CHK("above limit", 8'h05, u_mem.dmem[12'hF60])
        `AACBE_CHK("last result", 8'h05, result)
        `AACBE_CHK("result pulses", 2, nres)
        $display("test index_branch done");
        finish_test();
    end

    initial
    begin
        #(40 * 5000);
        fail_count++;
        $display("[ERR] watchdog expected done seen timeout");
        finish_test();
    end
endmodule
